/* src/fan_pkg.sv */
package fan_pkg;

  // Step codes: 0h off, 1h..Dh the thirteen duty steps, Eh/Fh reserved
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hD;

  // Duty in hundredths of a percent, indexed by step code
  localparam logic [13:0] DUTY_HI [14] = '{
    14'd0,    14'd2500, 14'd3125, 14'd3750, 14'd4375, 14'd5000, 14'd5625,
    14'd6250, 14'd6875, 14'd7500, 14'd8125, 14'd8750, 14'd9375, 14'd10000
  };
  localparam logic [13:0] DUTY_LO [14] = '{
    14'd0,    14'd2500, 14'd2857, 14'd3214, 14'd3571, 14'd3929, 14'd4286,
    14'd4643, 14'd5000, 14'd5357, 14'd5714, 14'd7143, 14'd8571, 14'd10000
  };

  // Timing: one millisecond at the 100 ns clock
  localparam int MS_NS         = 1000000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // Register indexes; byte address is four times the index
  localparam int REG_CTRL   = 0;
  localparam int REG_FREQ   = 1;
  localparam int REG_BIND   = 2;
  localparam int REG_MANUAL = 3;
  localparam int REG_SPIN   = 4;
  localparam int REG_RAMP   = 5;
  localparam int REG_ZONE4  = 6;
  localparam int REG_TBASE  = 7;
  localparam int REG_OFF12L = 8;
  localparam int REG_OFF12H = 9;
  localparam int REG_OFF34L = 10;
  localparam int REG_OFF34H = 11;
  localparam int REG_BOOST  = 12;
  localparam int REG_HYST   = 13;
  localparam int REG_STATUS = 14;
  localparam int REG_NUM_RW = 14;
  localparam int REG_NUM    = 15;

  // Field positions
  localparam int CTRL_FORCE   = 0;
  localparam int CTRL_HALF12  = 1;
  localparam int CTRL_HALF34  = 2;
  localparam int BIND_ZONE    = 0;  // 4 bits per output, from here
  localparam int BIND_VR      = 8;  // 2 bits per output, from here
  localparam int MAN_STRIDE   = 8;  // enable at +0, code at +4
  localparam int SPIN_CODE    = 0;
  localparam int SPIN_MS      = 8;
  localparam int OFFS_BITS    = 48;

  // Every writable register resets to zero
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Zone temperatures from the measurement path, in 0.5 degree units
  typedef struct packed {
    logic [8:0] zone3;
    logic [8:0] zone2;
    logic [8:0] zone1;
  } zone_temps_s;

  // Final answer for one PWM output
  typedef struct packed {
    logic [3:0]  code;
    logic [13:0] duty;
  } pwm_out_s;

endpackage : fan_pkg

/* src/vr_ramp.sv */
// One regulator-hot ramp for one output
module vr_ramp (
  input  wire logic       clk,        // System clock
  input  wire logic       rstn,       // Synchronous reset, active low
  input  wire logic       bound,      // Hot input bound to this output
  input  wire logic       hot,        // Synchronised hot level, active high
  input  wire logic       tick,       // One pulse per ramp interval
  input  wire logic [3:0] other_code, // Code requested by other functions
  output logic            active,     // Ramp enabled
  output logic [3:0]      code        // Ramp request
);

  function automatic logic [3:0] step_up(input logic [3:0] c);
    step_up = (c >= fan_pkg::CODE_MAX) ? fan_pkg::CODE_MAX : c + 4'h1;
  endfunction : step_up

  logic       active_q;
  logic [3:0] code_q;

  // Enable, step and disable; retrigger only from the disabled state
  always_ff @(posedge clk) begin
    if (!rstn || !bound) begin
      active_q <= 1'b0;
      code_q   <= fan_pkg::CODE_OFF;
    end else if (!active_q) begin
      if (hot) begin
        active_q <= 1'b1;
        code_q   <= step_up(other_code);
      end
    end else if (!hot && code_q < other_code) begin
      active_q <= 1'b0;
      code_q   <= fan_pkg::CODE_OFF;
    end else if (tick) begin
      if (hot) begin
        code_q <= step_up(code_q);
      end else if (code_q != fan_pkg::CODE_OFF) begin
        code_q <= code_q - 4'h1;
      end
    end
  end

  assign active = active_q;
  assign code   = code_q;

endmodule : vr_ramp

/* src/fan_pwm_duty_arbiter.sv */
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
module fan_pwm_duty_arbiter #(
  parameter int MS_CYCLES = fan_pkg::MS_CYCLES  // Clocks per millisecond
) (
  input  wire logic                  clk,        // 10 MHz system clock
  input  wire logic                  rstn,       // Sync reset, active low
  input  wire logic                  hsel,       // AHB slave select
  input  wire logic [31:0]           haddr,      // AHB address
  input  wire logic [1:0]            htrans,     // AHB transfer type
  input  wire logic                  hwrite,     // AHB write
  input  wire logic [2:0]            hsize,      // AHB size
  input  wire logic [31:0]           hwdata,     // AHB write data
  input  wire logic                  hready,     // AHB bus ready
  output logic                       hreadyout,  // Always ready
  output logic                       hresp,      // Always OKAY
  output logic [31:0]                hrdata,     // Read data
  input  wire fan_pkg::zone_temps_s  zone_temps, // Zones 1-3, 0.5 deg units
  input  wire logic [1:0][3:0]       cpu_ramp_code, // Processor ramp codes
  input  wire logic                  regulator_one_hot_input_n, // Pin
  input  wire logic                  regulator_two_hot_input_n, // Pin
  output fan_pkg::pwm_out_s [1:0]    pwm_duty    // Final code and duty
);

  function automatic logic [3:0] max2(input logic [3:0] a,
                                      input logic [3:0] b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  // Reserved codes written by software are treated as full speed
  function automatic logic [3:0] clamp(input logic [3:0] c);
    clamp = (c > fan_pkg::CODE_MAX) ? fan_pkg::CODE_MAX : c;
  endfunction : clamp

  // Offset or hysteresis weight in 0.5 degree units
  function automatic logic [10:0] weigh(input logic [3:0] v,
                                        input logic half);
    weigh = half ? {7'h00, v} : {6'h00, v, 1'b0};
  endfunction : weigh

  // Lookup: base, then twelve cumulative offsets to thirteen steps
  function automatic logic [3:0] lut_code(input logic [8:0] t,
                                          input logic [7:0] base,
                                          input logic [47:0] offs,
                                          input logic half);
    logic [10:0] thr;
    logic [3:0]  c;
    thr = {2'b00, base, 1'b0};
    c   = fan_pkg::CODE_OFF;
    if ({2'b00, t} >= thr) begin
      c = 4'h1;
    end
    for (int k = 0; k < 12; k++) begin
      thr = thr + weigh(offs[k*4 +: 4], half);
      if ({2'b00, t} >= thr && c == 4'(k + 1)) begin
        c = 4'(k + 2);
      end
    end
    lut_code = c;
  endfunction : lut_code

  function automatic logic [13:0] to_duty(input logic [3:0] c,
                                          input logic low);
    to_duty = low ? fan_pkg::DUTY_LO[clamp(c)] : fan_pkg::DUTY_HI[clamp(c)];
  endfunction : to_duty

  // Bus and register state
  logic [31:0] regs_q [fan_pkg::REG_NUM_RW];
  logic        wr_pend_q;
  logic [3:0]  wr_idx_q;
  logic [31:0] hrdata_q;
  logic [31:0] status;
  logic        addr_ok;
  logic [3:0]  addr_idx;
  logic        phase_ok;

  assign addr_idx = haddr[5:2];
  assign addr_ok  = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'b00) &&
                    (addr_idx < 4'(fan_pkg::REG_NUM));
  assign phase_ok = hsel && htrans[1] && hready && addr_ok &&
                    (hsize == 3'b010);

  // Address phase: note a word write for the data phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 4'h0;
    end else if (hready) begin
      wr_pend_q <= phase_ok && hwrite &&
                   (addr_idx < 4'(fan_pkg::REG_NUM_RW));
      wr_idx_q  <= addr_idx;
    end
  end

  // Data phase write into the register array
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < fan_pkg::REG_NUM_RW; i++) begin
        regs_q[i] <= fan_pkg::REG_RESET;
      end
    end else if (wr_pend_q) begin
      regs_q[wr_idx_q] <= hwdata;
    end
  end

  // Read data is registered; a write still in its data phase is bypassed
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (hready) begin
      if (!(phase_ok && !hwrite)) begin
        hrdata_q <= 32'h0000_0000;
      end else if (addr_idx == 4'(fan_pkg::REG_STATUS)) begin
        hrdata_q <= status;
      end else if (wr_pend_q && wr_idx_q == addr_idx) begin
        hrdata_q <= hwdata;
      end else begin
        hrdata_q <= regs_q[addr_idx];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Field views
  logic        force_full_speed_bit;
  logic        half12;
  logic        half34;
  logic [1:0]  pwm_frequency_select_reg;
  logic [7:0]  ramp_ms;
  logic [7:0]  spin_ms;
  logic [3:0]  spin_code;

  assign force_full_speed_bit = regs_q[fan_pkg::REG_CTRL][fan_pkg::CTRL_FORCE];
  assign half12   = regs_q[fan_pkg::REG_CTRL][fan_pkg::CTRL_HALF12];
  assign half34   = regs_q[fan_pkg::REG_CTRL][fan_pkg::CTRL_HALF34];
  assign pwm_frequency_select_reg = regs_q[fan_pkg::REG_FREQ][1:0];
  assign ramp_ms   = regs_q[fan_pkg::REG_RAMP][7:0];
  assign spin_ms   = regs_q[fan_pkg::REG_SPIN][fan_pkg::SPIN_MS +: 8];
  assign spin_code = clamp(regs_q[fan_pkg::REG_SPIN][fan_pkg::SPIN_CODE +: 4]);

  // Hot pins are active low and asynchronous: two flops before use
  logic [1:0] hot_meta_q;
  logic [1:0] hot_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hot_meta_q <= 2'b00;
      hot_q      <= 2'b00;
    end else begin
      hot_meta_q <= {~regulator_two_hot_input_n, ~regulator_one_hot_input_n};
      hot_q      <= hot_meta_q;
    end
  end

  // Millisecond enable and ramp interval enable
  logic [15:0] ms_cnt_q;
  logic        ms_tick;
  logic [7:0]  ramp_cnt_q;
  logic        ramp_tick;
  assign ms_tick   = (ms_cnt_q == 16'(MS_CYCLES - 1));
  assign ramp_tick = ms_tick && (ramp_cnt_q == 8'h00);
  always_ff @(posedge clk) begin
    if (!rstn || ms_tick) begin
      ms_cnt_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 16'h0001;
    end
  end

  // Interval of X ms; zero is taken as one
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ramp_cnt_q <= 8'h00;
    end else if (ms_tick) begin
      ramp_cnt_q <= (ramp_cnt_q == 8'h00) ?
                    ((ramp_ms == 8'h00) ? 8'h00 : ramp_ms - 8'h01) :
                    ramp_cnt_q - 8'h01;
    end
  end

  // Zones 1-3 at the resolution of their table pair; zone 4 is always whole degrees
  logic [3:0][8:0] temp_eff;
  logic [3:0]      zone_half;
  assign zone_half = {half34, half34, half12, half12};
  // whole-degree mode drops the half bit
  assign temp_eff[0] = half12 ? zone_temps.zone1 : {zone_temps.zone1[8:1], 1'b0};
  assign temp_eff[1] = half12 ? zone_temps.zone2 : {zone_temps.zone2[8:1], 1'b0};
  assign temp_eff[2] = half34 ? zone_temps.zone3 : {zone_temps.zone3[8:1], 1'b0};
  assign temp_eff[3] = {regs_q[fan_pkg::REG_ZONE4][7:0], 1'b0};

  // Per-zone lookup code and boost state
  logic [3:0][3:0] zone_code;
  logic [3:0]      boost_q;
  for (genvar z = 0; z < 4; z++) begin : g_zone
    localparam int PAIR = z / 2;
    logic [7:0]  base;
    logic [47:0] offs;
    logic [7:0]  limit;
    logic [3:0]  hyst;
    assign base  = regs_q[fan_pkg::REG_TBASE][PAIR*8 +: 8];
    assign offs  = {regs_q[fan_pkg::REG_OFF12H + 2*PAIR][15:0],
                    regs_q[fan_pkg::REG_OFF12L + 2*PAIR]};
    assign limit = regs_q[fan_pkg::REG_BOOST][z*8 +: 8];
    assign hyst  = regs_q[fan_pkg::REG_HYST][z*4 +: 4];
    assign zone_code[z] = lut_code(temp_eff[z], base, offs, zone_half[z]);

    // Boost holds until the zone drops below limit minus hysteresis
    always_ff @(posedge clk) begin
      if (!rstn) begin
        boost_q[z] <= 1'b0;
      end else if ({2'b00, temp_eff[z]} >= {2'b00, limit, 1'b0}) begin
        boost_q[z] <= 1'b1;
      end else if ({2'b00, temp_eff[z]} + weigh(hyst, zone_half[z]) <
                   {2'b00, limit, 1'b0}) begin
        boost_q[z] <= 1'b0;
      end
    end
  end

  // Per-output arbitration
  logic [1:0][3:0] final_code;
  logic [1:0][3:0] ramp_code;
  logic [3:0]      ramp_act;
  logic [1:0]      spin_act;
  logic [1:0]      manual_en;
  logic [1:0][3:0] prev_code_q;

  for (genvar o = 0; o < 2; o++) begin : g_out
    logic [3:0] zbind;
    logic [1:0] vbind;
    logic [3:0] auto_code;
    logic [3:0] man_code;
    logic [3:0] full_code;
    logic [3:0] other_code;
    logic [3:0] spin_req;
    logic [1:0][3:0] vr_code;
    logic [7:0] spin_cnt_q;
    logic       spin_q;

    assign zbind = regs_q[fan_pkg::REG_BIND][fan_pkg::BIND_ZONE + o*4 +: 4];
    assign vbind = regs_q[fan_pkg::REG_BIND][fan_pkg::BIND_VR + o*2 +: 2];
    assign manual_en[o] = regs_q[fan_pkg::REG_MANUAL][o*fan_pkg::MAN_STRIDE];
    assign man_code = clamp(regs_q[fan_pkg::REG_MANUAL]
                            [o*fan_pkg::MAN_STRIDE + 4 +: 4]);

    // only bound zones count; code later mapped per output
    always_comb begin
      auto_code = fan_pkg::CODE_OFF;
      for (int z = 0; z < 4; z++) begin
        if (zbind[z]) begin
          auto_code = max2(auto_code, zone_code[z]);
        end
      end
    end

    // boost forces full; control bit forces full
    assign full_code = (force_full_speed_bit || (|boost_q)) ?
                       fan_pkg::CODE_MAX : fan_pkg::CODE_OFF;
    assign spin_req  = spin_q ? spin_code : fan_pkg::CODE_OFF;

    // manual replaces spin-up and automatic control
    assign other_code = manual_en[o] ?
      max2(max2(full_code, clamp(cpu_ramp_code[o])), man_code) :
      max2(max2(full_code, clamp(cpu_ramp_code[o])),
           max2(spin_req, auto_code));

    // one ramp per hot input per output
    for (genvar v = 0; v < 2; v++) begin : g_vr
      vr_ramp u_ramp (
        .clk        (clk),
        .rstn       (rstn),
        .bound      (vbind[v]),
        .hot        (hot_q[v]),
        .tick       (ramp_tick),
        .other_code (other_code),
        .active     (ramp_act[o*2 + v]),
        .code       (vr_code[v])
      );
    end

    assign ramp_code[o]  = max2(vr_code[0], vr_code[1]);
    assign final_code[o] = max2(other_code, ramp_code[o]);

    // spin-up on zero to nonzero, for the programmed ms
    always_ff @(posedge clk) begin
      if (!rstn || manual_en[o]) begin
        spin_q     <= 1'b0;
        spin_cnt_q <= 8'h00;
      end else if (prev_code_q[o] == fan_pkg::CODE_OFF &&
                   final_code[o] != fan_pkg::CODE_OFF && !spin_q &&
                   spin_ms != 8'h00) begin
        spin_q     <= 1'b1;
        spin_cnt_q <= spin_ms;
      end else if (spin_q && ms_tick) begin
        spin_cnt_q <= spin_cnt_q - 8'h01;
        spin_q     <= (spin_cnt_q != 8'h01);
      end
    end
    assign spin_act[o] = spin_q;

    // Registered outputs; frequency select picks the table
    always_ff @(posedge clk) begin
      if (!rstn) begin
        prev_code_q[o]   <= fan_pkg::CODE_OFF;
        pwm_duty[o].code <= fan_pkg::CODE_OFF;
        pwm_duty[o].duty <= 14'd0;
      end else begin
        prev_code_q[o]   <= final_code[o];
        pwm_duty[o].code <= final_code[o];
        pwm_duty[o].duty <= to_duty(final_code[o],
                                    pwm_frequency_select_reg[o]);
      end
    end
  end

  // Status word: live codes, boost, ramps and spin-up
  assign status = {14'h0000, spin_act, ramp_act, boost_q,
                   final_code[1], final_code[0]};

endmodule : fan_pwm_duty_arbiter

/* bench/vr_hot_model.sv */
module vr_hot_model #(
  parameter int DLY_NS = 130  // Pin delay, longer than a clock on purpose
) (
  input  wire logic [1:0] hot_req,                   // Overheat, per regulator
  output wire logic       regulator_one_hot_input_n, // Hot pin, active low
  output wire logic       regulator_two_hot_input_n  // Hot pin, active low
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins are asynchronous to the fan clock, so they move off the edges
  assign #(DLY_NS) regulator_one_hot_input_n = !hot_req[0];
  assign #(DLY_NS) regulator_two_hot_input_n = !hot_req[1];
endmodule : vr_hot_model

/* bench/fan_arb_monitor.sv */
module fan_arb_monitor #(
  parameter int MS_CYCLES = 10  // Clocks per millisecond
) (
  input wire logic                 clk,        // System clock
  input wire logic                 rstn,       // Sync reset, active low
  input wire logic                 hsel,       // Slave select
  input wire logic [31:0]          haddr,      // Address
  input wire logic [1:0]           htrans,     // Transfer type
  input wire logic                 hwrite,     // Write
  input wire logic [2:0]           hsize,      // Size
  input wire logic [31:0]          hwdata,     // Write data
  input wire logic                 hready,     // Bus ready
  input wire logic                 hreadyout,  // Slave ready
  input wire logic                 hresp,      // Response
  input wire logic [31:0]          hrdata,     // Read data
  input wire fan_pkg::zone_temps_s zone_temps, // Zone temperatures
  input wire logic [1:0][3:0]      cpu_ramp_code, // Processor ramp codes
  input wire logic                 regulator_one_hot_input_n, // Hot pin
  input wire logic                 regulator_two_hot_input_n, // Hot pin
  input wire fan_pkg::pwm_out_s [1:0] pwm_duty // Final code and duty
);
  timeunit 1ns;
  timeprecision 1ns;

  logic        acc;
  logic        wr_q;
  logic [31:0] wa_q;
  logic        force_q;
  logic [1:0]  freq_q;
  logic        man_en_q;
  logic [3:0]  man_q;

  // Accepted address phase
  assign acc = hsel && htrans[1] && hready;

  // Shadow of control writes, so no check needs to peek inside
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_q     <= 1'b0;
      wa_q     <= 32'h0;
      force_q  <= 1'b0;
      freq_q   <= 2'h0;
      man_en_q <= 1'b0;
      man_q    <= 4'h0;
    end else begin
      wr_q <= acc && hwrite;
      wa_q <= haddr;
      if (wr_q && wa_q == 32'(fan_pkg::REG_CTRL * 4)) begin
        force_q <= hwdata[fan_pkg::CTRL_FORCE];
      end
      if (wr_q && wa_q == 32'(fan_pkg::REG_FREQ * 4)) begin
        freq_q <= hwdata[1:0];
      end
      if (wr_q && wa_q == 32'(fan_pkg::REG_MANUAL * 4)) begin
        man_en_q <= hwdata[0];
        man_q    <= (hwdata[7:4] > fan_pkg::CODE_MAX) ?
                    fan_pkg::CODE_MAX : hwdata[7:4];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_ready_always: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not OKAY");
  a_write_zero_rdata: assert property (acc && hwrite |=> hrdata == 32'h0)
    else $error("hrdata not zero after write");
  a_unmapped_reads_zero: assert property (
    acc && !hwrite && haddr >= 32'h3C |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_code_in_range: assert property (
    pwm_duty[0].code <= fan_pkg::CODE_MAX &&
    pwm_duty[1].code <= fan_pkg::CODE_MAX)
    else $error("reserved code produced");
  a_high_freq_table: assert property (
    !freq_q[0] && !$past(freq_q[0]) |->
    pwm_duty[0].duty == fan_pkg::DUTY_HI[pwm_duty[0].code])
    else $error("output 0 duty off table");
  a_low_freq_table: assert property (
    freq_q[1] && $past(freq_q[1]) |->
    pwm_duty[1].duty == fan_pkg::DUTY_LO[pwm_duty[1].code])
    else $error("output 1 duty off table");
  a_force_full_both: assert property (
    force_q |=> pwm_duty[0].code == fan_pkg::CODE_MAX &&
    pwm_duty[1].code == fan_pkg::CODE_MAX)
    else $error("force full ignored");
  a_manual_floor: assert property (
    man_en_q |=> pwm_duty[0].code >= $past(man_q))
    else $error("output 0 below manual code");
endmodule : fan_arb_monitor

bind fan_pwm_duty_arbiter fan_arb_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
  .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .zone_temps(zone_temps), .cpu_ramp_code(cpu_ramp_code),
  .regulator_one_hot_input_n(regulator_one_hot_input_n),
  .regulator_two_hot_input_n(regulator_two_hot_input_n),
  .pwm_duty(pwm_duty));

/* bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                   clk = 1'b0;
  logic                   rstn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]            haddr, hwdata, hrdata, rd_d;
  logic [1:0]             htrans, hot_req;
  logic [2:0]             hsize;
  fan_pkg::zone_temps_s   zt;
  logic [1:0][3:0]        cpu_code;
  logic                   one_n, two_n;
  fan_pkg::pwm_out_s [1:0] pwm;
  int                     n_mismatch = 0;
  int                     num_checks = 0;
  int                     cyc = 0;

  // Short millisecond keeps every ramp interval brief
  fan_pwm_duty_arbiter #(.MS_CYCLES(10)) DUT (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .zone_temps(zt), .cpu_ramp_code(cpu_code),
    .regulator_one_hot_input_n(one_n), .regulator_two_hot_input_n(two_n),
    .pwm_duty(pwm));

  // Slow partner: pin edges land more than a clock after the request
  vr_hot_model #(.DLY_NS(130)) hot_src (
    .hot_req(hot_req), .regulator_one_hot_input_n(one_n),
    .regulator_two_hot_input_n(two_n));

  always #50 clk = ~clk;

  // Hang guard, far above the roughly 1200 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task end_of_test();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One single word transfer; waits on ready, never on a fixed count
  task bus(input int i, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= 32'(i * 4);
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_d = hrdata;
    hsel <= 1'b0;
  endtask : bus

  task settle(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : settle

  task out(input int o, input logic [3:0] c, input logic lo);
    chk("code", 32'(c), 32'(pwm[o].code));
    chk("duty", lo ? fan_pkg::DUTY_LO[c] : fan_pkg::DUTY_HI[c],
        32'(pwm[o].duty));
  endtask : out

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    zt = '0;
    cpu_code = '0;
    hot_req = 2'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // Register reset values, then a hole in the map
    for (int i = 0; i < fan_pkg::REG_NUM_RW; i++) begin
      bus(i, 1'b0, 32'h0);
      chk("reset value", fan_pkg::REG_RESET, rd_d);
    end
    bus(fan_pkg::REG_NUM, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd_d);
    bus(fan_pkg::REG_BOOST, 1'b1, 32'hFFFF_FFFF);
    bus(fan_pkg::REG_FREQ, 1'b1, 32'h2);
    // Every manual code on both tables, reserved code last
    for (int c = 0; c < 15; c++) begin
      bus(fan_pkg::REG_MANUAL, 1'b1, 32'h101 | (c << 12) | (c << 4));
      settle(3);
      out(0, (c > 13) ? 4'hD : 4'(c), 1'b0);
      out(1, (c > 13) ? 4'hD : 4'(c), 1'b1);
    end
    // Manual override replaces the lookup result on output 0
    bus(fan_pkg::REG_MANUAL, 1'b1, 32'h31);
    bus(fan_pkg::REG_TBASE, 1'b1, 32'h2828);
    for (int i = fan_pkg::REG_OFF12L; i <= fan_pkg::REG_OFF34H; i++) begin
      bus(i, 1'b1, 32'h1111_1111);
    end
    bus(fan_pkg::REG_BIND, 1'b1, 32'h11);
    bus(fan_pkg::REG_BIND, 1'b0, 32'h0);
    chk("bind", 32'h11, rd_d);
    @(posedge clk) zt.zone1 <= 9'h59;
    settle(3);
    out(0, 4'h3, 1'b0);
    out(1, 4'h5, 1'b1);
    @(posedge clk) cpu_code[0] <= 4'hC;
    settle(3);
    out(0, 4'hC, 1'b0);
    @(posedge clk) cpu_code[0] <= 4'h0;
    bus(fan_pkg::REG_MANUAL, 1'b1, 32'h0);
    settle(3);
    out(0, 4'h5, 1'b0);
    // Half-degree steps turn 44.5 degrees into more steps
    bus(fan_pkg::REG_CTRL, 1'b1, 32'h2);
    settle(3);
    out(0, 4'hA, 1'b0);
    out(1, 4'hA, 1'b1);
    // Zone 4 alone drives output 0
    bus(fan_pkg::REG_ZONE4, 1'b1, 32'h2D);
    bus(fan_pkg::REG_BIND, 1'b1, 32'h8);
    bus(fan_pkg::REG_CTRL, 1'b1, 32'h0);
    settle(3);
    out(0, 4'h6, 1'b0);
    out(1, 4'h0, 1'b1);
    bus(fan_pkg::REG_CTRL, 1'b1, 32'h6);
    settle(3);
    out(0, 4'hB, 1'b0);
    // Zone 1 boost, hysteresis in half degrees, outputs unbound
    bus(fan_pkg::REG_CTRL, 1'b1, 32'h2);
    bus(fan_pkg::REG_BIND, 1'b1, 32'h0);
    bus(fan_pkg::REG_HYST, 1'b1, 32'h2);
    bus(fan_pkg::REG_BOOST, 1'b1, 32'hFFFF_FF2D);
    @(posedge clk) zt.zone1 <= 9'h5A;
    settle(3);
    out(0, 4'hD, 1'b0);
    out(1, 4'hD, 1'b1);
    @(posedge clk) zt.zone1 <= 9'h58;
    settle(3);
    out(1, 4'hD, 1'b1);
    @(posedge clk) zt.zone1 <= 9'h57;
    settle(3);
    out(1, 4'h0, 1'b1);
    // Force full, then release
    bus(fan_pkg::REG_CTRL, 1'b1, 32'h3);
    settle(3);
    out(0, 4'hD, 1'b0);
    out(1, 4'hD, 1'b1);
    bus(fan_pkg::REG_CTRL, 1'b1, 32'h0);
    settle(3);
    out(1, 4'h0, 1'b1);
    // Regulator one ramps output 0 only, one step per millisecond
    bus(fan_pkg::REG_BOOST, 1'b1, 32'hFFFF_FFFF);
    bus(fan_pkg::REG_RAMP, 1'b1, 32'h1);
    bus(fan_pkg::REG_BIND, 1'b1, 32'h101);
    @(posedge clk) zt.zone1 <= 9'h59;
    settle(3);
    @(posedge clk) hot_req <= 2'h1;
    settle(6);
    chk("ramp start", 32'h1, 32'(pwm[0].code inside {4'h6, 4'h7}));
    out(1, 4'h0, 1'b1);
    settle(150);
    out(0, 4'hD, 1'b0);
    @(posedge clk) hot_req <= 2'h0;
    settle(40);
    chk("ramp down", 32'h1, 32'(pwm[0].code inside {[4'h8:4'hB]}));
    settle(200);
    out(0, 4'h5, 1'b0);
    // Regulator two takes over a shared output; a short blip never
    // retriggers, and the blip outlasts the pin delay so it gets through
    bus(fan_pkg::REG_BIND, 1'b1, 32'h301);
    @(posedge clk) hot_req <= 2'h1;
    settle(150);
    @(posedge clk) hot_req <= 2'h2;
    settle(150);
    out(0, 4'hD, 1'b0);
    @(posedge clk) hot_req <= 2'h0;
    repeat (3) @(posedge clk);
    hot_req <= 2'h2;
    settle(6);
    chk("no retrigger", 32'h1, 32'(pwm[0].code inside {4'hC, 4'hD}));
    @(posedge clk) hot_req <= 2'h0;
    settle(200);
    out(0, 4'h5, 1'b0);
    // Spin-up from a stopped fan
    bus(fan_pkg::REG_SPIN, 1'b1, 32'h20C);
    @(posedge clk) zt.zone1 <= 9'h46;
    settle(3);
    out(0, 4'h0, 1'b0);
    @(posedge clk) zt.zone1 <= 9'h59;
    settle(5);
    out(0, 4'hC, 1'b0);
    settle(40);
    out(0, 4'h5, 1'b0);
    end_of_test();
  end
endmodule : tb_top
